/* design/iop_programmable_io_port.sv */
// programmable pin port: mode, direction and value bits for 32 pins behind AXI4-Lite
// assumes pad ring combines drive/enable/pull outputs; pin inputs asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - output pins drive their value bit
// - input pins capture level into value bit
// - mode 0: normal, or pulled input
// - mode 1: driven output, or unpulled input
// - direction 1 is input; 0 is output in mode 1, normal in mode 0
// - low registers pins 0-15, high 16-31
// - mode bit n controls pin n
// - low direction resets to fc0f
// - high direction resets to all ones
// - low mode resets to zero
// - value registers reset to zero
// - pins 4,5,7-9 pull up, 6 down
// - low strap at reset forces pins 26,29 normal
// - high mode resets to zero
module iop_programmable_io_port
  import iop_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [IOP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [IOP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] programmable_pin_in,
  input wire logic refresh_address_enable_strap,
  output logic [31:0] programmable_pin_out,
  output logic [31:0] programmable_pin_oe,
  output logic [31:0] programmable_pin_pull_en,
  output logic [31:0] programmable_pin_pull_down,
  output logic [31:0] programmable_pin_normal_fn
);

  iop_cfg_t cfg;
  iop_pad_t next_pad;
  logic [31:0] pin_meta;
  logic [31:0] pin_sync;
  logic strap_armed;
  logic strap_force;
  logic [31:0] force_mask;

  logic aw_held;
  logic w_held;
  logic [6:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic wr_hit;
  logic [6:0] rd_idx;
  logic rd_hit;
  logic [15:0] rd_val;
  logic [31:0] value_wr_mask;
  logic [31:0] value_wr_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // register decode helpers

  function automatic logic iop_mapped(input logic [6:0] idx);
    case (idx)
      IOP_IDX_MODE_LOW, IOP_IDX_DIR_LOW, IOP_IDX_VALUE_LOW,
      IOP_IDX_MODE_HIGH, IOP_IDX_DIR_HIGH, IOP_IDX_VALUE_HIGH: iop_mapped = 1'b1;
      default: iop_mapped = 1'b0;
    endcase
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] iop_merge(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    iop_merge = old;
    if (strb[0]) begin
      iop_merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      iop_merge[15:8] = data[15:8];
    end
  endfunction

  // a write is granted once both halves are held and the last response has gone
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = iop_mapped(aw_idx);
  assign rd_idx = s_axi_araddr[IOP_IDX_LSB +: 7];
  assign rd_hit = iop_mapped(rd_idx);

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order, response after both

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_idx <= 7'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx <= s_axi_awaddr[IOP_IDX_LSB +: 7];
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_held) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_held) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IOP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? IOP_RESP_OKAY : IOP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel: data one cycle after the address is taken

  always_comb begin
    rd_val = 16'h0000;
    case (rd_idx)
      IOP_IDX_MODE_LOW: rd_val = cfg.mode[IOP_HALF-1:0];
      IOP_IDX_DIR_LOW: rd_val = cfg.dir[IOP_HALF-1:0];
      IOP_IDX_VALUE_LOW: rd_val = cfg.value[IOP_HALF-1:0];
      IOP_IDX_MODE_HIGH: rd_val = cfg.mode[IOP_PINS-1:IOP_HALF];
      IOP_IDX_DIR_HIGH: rd_val = cfg.dir[IOP_PINS-1:IOP_HALF];
      IOP_IDX_VALUE_HIGH: rd_val = cfg.value[IOP_PINS-1:IOP_HALF];
      default: rd_val = 16'h0000;
    endcase
  end

  // unmapped reads answer with zero data and an error response
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= IOP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= rd_hit ? IOP_RESP_OKAY : IOP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode and direction registers

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg.mode <= {IOP_RST_MODE_HIGH, IOP_RST_MODE_LOW};
      cfg.dir <= {IOP_RST_DIR_HIGH, IOP_RST_DIR_LOW};
    end else if (wr_go) begin
      case (aw_idx)
        IOP_IDX_MODE_LOW: cfg.mode[IOP_HALF-1:0] <=
            iop_merge(cfg.mode[IOP_HALF-1:0], w_data, w_strb);
        IOP_IDX_MODE_HIGH: cfg.mode[IOP_PINS-1:IOP_HALF] <=
            iop_merge(cfg.mode[IOP_PINS-1:IOP_HALF], w_data, w_strb);
        IOP_IDX_DIR_LOW: cfg.dir[IOP_HALF-1:0] <=
            iop_merge(cfg.dir[IOP_HALF-1:0], w_data, w_strb);
        IOP_IDX_DIR_HIGH: cfg.dir[IOP_PINS-1:IOP_HALF] <=
            iop_merge(cfg.dir[IOP_PINS-1:IOP_HALF], w_data, w_strb);
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_meta <= 32'h00000000;
      pin_sync <= 32'h00000000;
    end else begin
      pin_meta <= programmable_pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // value write lanes: which bits a granted write replaces, and with what

  always_comb begin
    value_wr_mask = 32'h00000000;
    value_wr_bits = {w_data[IOP_HALF-1:0], w_data[IOP_HALF-1:0]};
    if (wr_go) begin
      case (aw_idx)
        IOP_IDX_VALUE_LOW: begin
          if (w_strb[0]) begin
            value_wr_mask[7:0] = 8'hff;
          end
          if (w_strb[1]) begin
            value_wr_mask[15:8] = 8'hff;
          end
        end
        IOP_IDX_VALUE_HIGH: begin
          if (w_strb[0]) begin
            value_wr_mask[23:16] = 8'hff;
          end
          if (w_strb[1]) begin
            value_wr_mask[31:24] = 8'hff;
          end
        end
        default: begin
          value_wr_mask = 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // value register: software writes, input pins overwrite with sampled level

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg.value <= {IOP_RST_VALUE, IOP_RST_VALUE};
    end else begin
      for (int i = 0; i < IOP_PINS; i++) begin
        if (cfg.dir[i]) begin
          // the sampled level wins over a software write in the same cycle
          cfg.value[i] <= pin_sync[i];
        end else if (value_wr_mask[i]) begin
          cfg.value[i] <= value_wr_bits[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strap captured on the first edge after reset release
  // looked at once only: later changes on the strap pin have no effect

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strap_armed <= 1'b1;
      strap_force <= 1'b0;
    end else if (strap_armed) begin
      strap_armed <= 1'b0;
      strap_force <= !refresh_address_enable_strap;
    end
  end

  // forced pins ignore their mode and direction bits until the next reset
  assign force_mask = strap_force ? IOP_STRAP_FORCE_MASK : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin function decode

  for (genvar n = 0; n < IOP_PINS; n++) begin : g_pin
    iop_fn_t fn;
    assign fn = force_mask[n] ? IOP_FN_NORMAL : iop_fn_t'({cfg.mode[n], cfg.dir[n]});
    always_comb begin
      next_pad.drive[n] = cfg.value[n];
      next_pad.drive_en[n] = 1'b0;
      next_pad.pull_en[n] = 1'b0;
      next_pad.normal_fn[n] = 1'b0;
      case (fn)
        IOP_FN_NORMAL: next_pad.normal_fn[n] = 1'b1;
        IOP_FN_IN_PULL: next_pad.pull_en[n] = 1'b1;
        IOP_FN_OUTPUT: next_pad.drive_en[n] = 1'b1;
        IOP_FN_IN_PLAIN: next_pad.pull_en[n] = 1'b0;
        default: next_pad.normal_fn[n] = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered pad outputs
  // pads follow a register change one cycle later

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      programmable_pin_out <= 32'h00000000;
      programmable_pin_oe <= 32'h00000000;
      programmable_pin_pull_en <= 32'h00000000;
      programmable_pin_pull_down <= IOP_PULL_DOWN_MASK;
      programmable_pin_normal_fn <= 32'h00000000;
    end else begin
      programmable_pin_out <= next_pad.drive;
      programmable_pin_oe <= next_pad.drive_en;
      programmable_pin_pull_en <= next_pad.pull_en;
      programmable_pin_pull_down <= IOP_PULL_DOWN_MASK;
      programmable_pin_normal_fn <= next_pad.normal_fn;
    end
  end

endmodule

`default_nettype wire

/* design/iop_pkg.sv */
// package for the programmable pin port: register indexes, reset values, field layouts
// assumes a 32-bit AXI4-Lite register bus and 32 programmable pins
package iop_pkg;

  localparam int unsigned IOP_PINS = 32;
  localparam int unsigned IOP_HALF = 16;
  localparam int unsigned IOP_ADDR_W = 12;

  // register indexes as printed; byte address is four times the index
  localparam logic [6:0] IOP_IDX_MODE_LOW = 7'h70;
  localparam logic [6:0] IOP_IDX_DIR_LOW = 7'h72;
  localparam logic [6:0] IOP_IDX_VALUE_LOW = 7'h74;
  localparam logic [6:0] IOP_IDX_MODE_HIGH = 7'h76;
  localparam logic [6:0] IOP_IDX_DIR_HIGH = 7'h78;
  localparam logic [6:0] IOP_IDX_VALUE_HIGH = 7'h7a;
  localparam int unsigned IOP_IDX_LSB = 2;

  // values after reset
  localparam logic [15:0] IOP_RST_MODE_LOW = 16'h0000;
  localparam logic [15:0] IOP_RST_MODE_HIGH = 16'h0000;
  localparam logic [15:0] IOP_RST_DIR_LOW = 16'hfc0f;
  localparam logic [15:0] IOP_RST_DIR_HIGH = 16'hffff;
  localparam logic [15:0] IOP_RST_VALUE = 16'h0000;

  // pins whose pull resistor pulls down; all others pull up
  localparam logic [31:0] IOP_PULL_DOWN_MASK = 32'h00c00442;
  // pins that fall back to normal function when the strap is low at reset
  localparam logic [31:0] IOP_STRAP_FORCE_MASK = 32'h24000000;

  localparam logic [1:0] IOP_RESP_OKAY = 2'h0;
  localparam logic [1:0] IOP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    IOP_FN_NORMAL = 2'b00,
    IOP_FN_IN_PULL = 2'b01,
    IOP_FN_OUTPUT = 2'b10,
    IOP_FN_IN_PLAIN = 2'b11
  } iop_fn_t;

  // per-pin configuration bits, bit n belongs to pin n
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] dir;
    logic [31:0] value;
  } iop_cfg_t;

  // what the pad ring receives for every pin
  typedef struct packed {
    logic [31:0] drive;
    logic [31:0] drive_en;
    logic [31:0] pull_en;
    logic [31:0] normal_fn;
  } iop_pad_t;

endpackage

/* tb/iop_port_properties.sv */
// checker for the programmable pin port: bus handshakes and pad decode exclusivity
// assumes it is bound to the port's top module, one clock domain
`timescale 1ns/100ps
`default_nettype none
module iop_port_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] programmable_pin_oe,
  input wire logic [31:0] programmable_pin_pull_en,
  input wire logic [31:0] programmable_pin_pull_down,
  input wire logic [31:0] programmable_pin_normal_fn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_pull_side: assert property (programmable_pin_pull_down == 32'h00c00442)
    else $error("pull direction mask wrong");
  a_drive_no_pull: assert property ((programmable_pin_oe & programmable_pin_pull_en) == 0)
    else $error("driven pin also pulled");
  a_drive_no_normal: assert property ((programmable_pin_oe & programmable_pin_normal_fn) == 0)
    else $error("driven pin also normal");
  a_pull_no_normal: assert property ((programmable_pin_pull_en & programmable_pin_normal_fn) == 0)
    else $error("pulled pin also normal");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response dropped");
  a_write_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_read_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (programmable_pin_oe != 0);
  cover property (programmable_pin_normal_fn[26]);
endmodule
`default_nettype wire

/* tb/programmable_io_port_tb.sv */
// testbench for the programmable pin port: register traffic, pad decode, strap forcing
// assumes the package constants and one 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module programmable_io_port_tb import iop_pkg::*;;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic refresh_address_enable_strap, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [IOP_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, programmable_pin_in, s_axi_rdata, programmable_pin_out;
  logic [31:0] programmable_pin_oe, programmable_pin_pull_en, programmable_pin_pull_down;
  logic [31:0] programmable_pin_normal_fn;
  int failures, check_count;
  logic [31:0] seed = 32'hb26f9a29;
  logic [65:0] q[$];
  iop_programmable_io_port DUT (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .programmable_pin_in, .refresh_address_enable_strap,
    .programmable_pin_out, .programmable_pin_oe, .programmable_pin_pull_en,
    .programmable_pin_pull_down, .programmable_pin_normal_fn);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // oldest note is {resp, mask, data}
  task take(input logic [1:0] r, input logic [31:0] d);
    logic [65:0] x;
    x = q.pop_front();
    chk({30'h0, r}, {30'h0, x[65:64]});
    chk(d & x[63:32], x[31:0]);
  endtask
  always @(posedge core_clk) begin
    if (rst_n && s_axi_bvalid && s_axi_bready) take(s_axi_bresp, 32'h0);
    if (rst_n && s_axi_rvalid && s_axi_rready) take(s_axi_rresp, s_axi_rdata);
  end
  task wr(input logic [6:0] i, input logic [31:0] d, input logic [1:0] r, input int w = 0);
    int n;
    @(posedge core_clk);
    q.push_back({r, 64'h0});
    s_axi_awaddr <= {3'h0, i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (w == 0);
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (n + 1 >= w) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) begin
      failures++;
      final_report();
    end
  endtask
  task rd(input logic [6:0] i, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r,
          input int w = 0);
    int n;
    @(posedge core_clk);
    q.push_back({r, m, e});
    s_axi_araddr <= {3'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (w == 0);
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (n + 1 >= w) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (n == 100) begin
      failures++;
      final_report();
    end
  endtask
  task rst(input logic s);
    rst_n <= 1'b0;
    refresh_address_enable_strap <= s;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    int k;
    logic [31:0] m, d, v, p, e, km;
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    programmable_pin_in = 32'h0;
    refresh_address_enable_strap = 1'b1;
    rst(1'b1);
    rd(IOP_IDX_MODE_LOW, 32'h0, 32'hffffffff, IOP_RESP_OKAY);
    rd(IOP_IDX_DIR_LOW, 32'hfc0f, 32'hffffffff, IOP_RESP_OKAY);
    rd(IOP_IDX_MODE_HIGH, 32'h0, 32'hffffffff, IOP_RESP_OKAY);
    rd(IOP_IDX_DIR_HIGH, 32'hffff, 32'hffffffff, IOP_RESP_OKAY);
    chk(programmable_pin_pull_en, 32'hfffffc0f);
    chk(programmable_pin_normal_fn, 32'h000003f0);
    chk(programmable_pin_pull_down, 32'h00c00442);
    $display("test reset values done");
    for (k = 0; k < 6; k++) begin
      m = rnd();
      d = rnd();
      v = rnd();
      p = rnd();
      programmable_pin_in <= p;
      wr(IOP_IDX_MODE_LOW, m, IOP_RESP_OKAY, k % 4);
      wr(IOP_IDX_MODE_HIGH, {m[15:0], m[31:16]}, IOP_RESP_OKAY);
      wr(IOP_IDX_DIR_LOW, d, IOP_RESP_OKAY);
      wr(IOP_IDX_DIR_HIGH, {d[15:0], d[31:16]}, IOP_RESP_OKAY);
      wr(IOP_IDX_VALUE_LOW, v, IOP_RESP_OKAY);
      wr(IOP_IDX_VALUE_HIGH, {v[15:0], v[31:16]}, IOP_RESP_OKAY);
      repeat (2) @(posedge core_clk);
      chk(programmable_pin_oe, m & ~d);
      chk(programmable_pin_pull_en, ~m & d);
      chk(programmable_pin_normal_fn, ~m & ~d);
      chk(programmable_pin_out & m & ~d, v & m & ~d);
      e = (v & m & ~d) | (p & d);
      km = m | d;
      rd(IOP_IDX_VALUE_LOW, {16'h0, e[15:0]}, {16'hffff, km[15:0]}, IOP_RESP_OKAY);
      rd(IOP_IDX_VALUE_HIGH, {16'h0, e[31:16]}, {16'hffff, km[31:16]}, IOP_RESP_OKAY);
      rd(IOP_IDX_MODE_HIGH, {16'h0, m[31:16]}, 32'hffffffff, IOP_RESP_OKAY, k % 4);
      rd(IOP_IDX_DIR_LOW, {16'h0, d[15:0]}, 32'hffffffff, IOP_RESP_OKAY);
    end
    $display("test pin decode done");
    programmable_pin_in <= 32'h0;
    wr(IOP_IDX_MODE_LOW, 32'h1, IOP_RESP_OKAY);
    wr(IOP_IDX_DIR_LOW, 32'h0, IOP_RESP_OKAY);
    wr(IOP_IDX_VALUE_LOW, 32'h0, IOP_RESP_OKAY);
    for (k = 0; k < 4; k++) begin
      wr(IOP_IDX_DIR_LOW, {31'h0, ~k[0]}, IOP_RESP_OKAY);
      repeat (2) @(posedge core_clk);
      chk({29'h0, programmable_pin_oe[0], programmable_pin_pull_en[0],
           programmable_pin_out[0]}, {29'h0, k[0], 2'b00});
    end
    $display("test open drain done");
    wr(7'h7c, rnd(), IOP_RESP_SLVERR);
    rd(7'h00, 32'h0, 32'hffffffff, IOP_RESP_SLVERR);
    $display("test unmapped done");
    rst(1'b0);
    chk(programmable_pin_normal_fn, 32'h240003f0);
    chk(programmable_pin_pull_en, 32'hdbfffc0f);
    $display("test strap done");
    final_report();
  end
  initial begin
    repeat (50000) @(posedge core_clk);
    failures++;
    final_report();
  end
endmodule
bind iop_programmable_io_port iop_port_props u_props (.core_clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp,
  .programmable_pin_oe, .programmable_pin_pull_en, .programmable_pin_pull_down,
  .programmable_pin_normal_fn);
`default_nettype wire
